// [csc_pkg.sv]
// Package: timing counts, reset values and state codes of the sequencer
package csc_pkg;
   localparam int SYS_NS        = 25;
   localparam int CCLK_HALF_NS  = 50;
   localparam int CCLK_HALF     = (CCLK_HALF_NS + SYS_NS - 1) / SYS_NS;
   localparam int INIT_CLOCKS   = 16;
   localparam int INIT_PULSE_NS = 1000;
   localparam int INIT_PULSE    = (INIT_PULSE_NS + SYS_NS - 1) / SYS_NS;
   localparam int ERR_HOLD_NS   = 1000;
   localparam int ERR_HOLD      = (ERR_HOLD_NS + SYS_NS - 1) / SYS_NS;
   localparam int ROLE_WAIT     = 4;
   localparam int DONE_GRACE    = 16;
   // Pin order: bit 0 chip select, bit 1 output enable, bit 2 clock
   localparam logic [2:0] SYNC_RST = 3'h1;

   typedef enum logic [7:0] {
      ST_ROLE = 8'h01,
      ST_WAIT = 8'h02,
      ST_SEND = 8'h04,
      ST_CASC = 8'h08,
      ST_INIT = 8'h10,
      ST_IDLE = 8'h20,
      ST_ERR  = 8'h40,
      ST_DONE = 8'h80
   } csc_state_t;
endpackage

// [csc_sequencer.sv]
// Design: bitstream FIFO and cascaded serial configuration sequencer
`timescale 1ns/100ps

module csc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   input  wire logic         i_flush,
   input  wire logic         i_wr_valid,
   output logic              o_wr_ready,
   input  wire logic [W-1:0] i_wr_data,
   output logic              o_rd_valid,
   input  wire logic         i_rd_ready,
   output logic [W-1:0]      o_rd_data
);
   // Pointers wrap naturally, so the depth must be a power of two
   localparam int PW = $clog2(D);
   logic [W-1:0] mem_reg  [D];
   logic [W-1:0] mem_next [D];
   logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [PW:0]   cnt_reg, cnt_next;
   logic          push, pop;

   assign o_wr_ready = (cnt_reg != (PW+1)'(D)) & ~i_flush;
   assign o_rd_valid = (cnt_reg != '0) & ~i_flush;
   assign o_rd_data  = mem_reg[rp_reg];
   assign push       = i_wr_valid & o_wr_ready;
   assign pop        = o_rd_valid & i_rd_ready;

   always_comb begin
      wp_next  = push ? wp_reg + 1'b1 : wp_reg;
      rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
      cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      if (i_flush) begin
         wp_next  = '0;
         rp_next  = '0;
         cnt_next = '0;
      end
   end

   for (genvar g = 0; g < D; g++) begin : g_mem
      always_comb begin
         mem_next[g] = (push && wp_reg == PW'(g)) ? i_wr_data : mem_reg[g];
      end
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
         if (!i_resetn) begin
            mem_reg[g] <= '0;
         end else begin
            mem_reg[g] <= mem_next[g];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule

module csc_sequencer #(
   parameter int W          = 8,
   parameter int DEPTH      = 16,
   parameter int AW         = 24,
   parameter int CW         = 26,
   parameter int OWN_BITS   = 1024,
   parameter int CHAIN_BITS = 1024,
   parameter bit CASCADE_EN = 1'b1
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   input  wire logic         i_chip_select_n,
   input  wire logic         i_oe_in,
   output logic              o_oe_out,
   output logic              o_oe_oe_n,
   input  wire logic         i_config_clock,
   output logic              o_config_clock,
   output logic              o_config_clock_oe_n,
   output logic              o_data,
   output logic              o_data_oe_n,
   output logic              o_cascade_out_n,
   output logic              o_target_status_n,
   output logic              o_target_status_oe_n,
   input  wire logic         i_init_config_instruction,
   output logic              o_init_config_out_n,
   output logic              o_init_config_oe_n,
   input  wire logic         i_auto_restart,
   input  wire logic         i_mem_valid,
   output logic              o_mem_ready,
   input  wire logic [W-1:0] i_mem_data,
   output logic              o_mem_rewind
);
   localparam int INITC = csc_pkg::INIT_CLOCKS;
   localparam int EHOLD = csc_pkg::ERR_HOLD;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_in;
   logic [2:0] sync_reg [3];
   logic [2:0] sync_next [3];
   logic [2:0] stab_reg, stab_next;
   logic       cs_st, oe_st, cs_now;

   assign pin_in = {i_config_clock, i_oe_in, i_chip_select_n};
   assign cs_st  = stab_reg[0];
   assign oe_st  = stab_reg[1];
   // Settled select as it stands after this edge; the role needs it
   // one cycle before the stable copy catches up
   assign cs_now = stab_next[0];

   for (genvar g = 0; g < 3; g++) begin : g_sync
      always_comb begin
         sync_next[g] = {sync_reg[g][1:0], pin_in[g]};
         stab_next[g] = (sync_reg[g][1] == sync_reg[g][2]) ?
                        sync_reg[g][1] : stab_reg[g];
      end
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
         if (!i_resetn) begin
            sync_reg[g] <= {3{csc_pkg::SYNC_RST[g]}};
            stab_reg[g] <= csc_pkg::SYNC_RST[g];
         end else begin
            sync_reg[g] <= sync_next[g];
            stab_reg[g] <= stab_next[g];
         end
      end
   end

   // ------------------------------------------------------------
   // Bitstream buffer
   // ------------------------------------------------------------
   logic         f_valid, f_ready, pop, flush, restart;
   logic [W-1:0] f_data;

   csc_fifo #(.W(W), .D(DEPTH)) u_fifo (
      .i_clk_sys  (i_clk_sys),
      .i_resetn   (i_resetn),
      .i_flush    (flush),
      .i_wr_valid (i_mem_valid),
      .o_wr_ready (o_mem_ready),
      .i_wr_data  (i_mem_data),
      .o_rd_valid (f_valid),
      .i_rd_ready (f_ready),
      .o_rd_data  (f_data)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   csc_pkg::csc_state_t st_reg, st_next;
   logic          master_reg, master_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [CW-1:0] tot_reg, tot_next;
   logic [7:0]    cnt_reg, cnt_next;
   logic [3:0]    div_reg, div_next;
   logic          cclk_reg, cclk_next;
   logic [W-1:0]  sh_reg, sh_next;
   logic [7:0]    shc_reg, shc_next;
   logic          casc_n_reg, casc_n_next;
   logic          run, tick, stall, mrise, srise, rise, adv, exh;
   logic          rise_d_reg, rise_d_next;

   assign exh   = addr_reg == AW'(OWN_BITS);
   assign run   = master_reg & (st_reg == csc_pkg::ST_SEND
                  | st_reg == csc_pkg::ST_CASC
                  | st_reg == csc_pkg::ST_INIT);
   assign tick  = run & (div_reg == 4'(csc_pkg::CCLK_HALF - 1));
   // Master holds the clock high-going edge back while no bit is loaded
   assign stall = (st_reg == csc_pkg::ST_SEND) & (shc_reg == '0) & ~exh;
   assign mrise = tick & ~cclk_reg & ~stall;
   assign srise = stab_next[2] & ~stab_reg[2];
   assign rise  = master_reg ? mrise : srise;
   // Shift a cycle after the rise so data holds past the sampling edge
   assign adv   = rise_d_reg & oe_st & ~cs_st & ~exh
                  & (st_reg == csc_pkg::ST_SEND);
   assign f_ready = (shc_reg == '0) | (adv & shc_reg == 8'h01);
   assign pop     = f_ready & f_valid;
   assign restart = (st_reg == csc_pkg::ST_ERR) & i_auto_restart & oe_st
                    & (cnt_reg == 8'(EHOLD - 1));
   assign flush   = (~oe_st & st_reg != csc_pkg::ST_ROLE) | restart;

   always_comb begin
      st_next     = st_reg;
      master_next = master_reg;
      addr_next   = addr_reg;
      tot_next    = tot_reg;
      cnt_next    = cnt_reg;
      div_next    = '0;
      cclk_next   = 1'b0;
      sh_next     = sh_reg;
      shc_next    = shc_reg;
      rise_d_next = rise;
      if (run) begin
         div_next  = tick ? 4'h0 : div_reg + 4'h1;
         cclk_next = (tick && !(~cclk_reg && stall)) ? ~cclk_reg : cclk_reg;
      end
      if (adv) begin
         sh_next   = sh_reg >> 1;
         shc_next  = shc_reg - 8'h01;
         addr_next = addr_reg + AW'(1);
      end
      if (pop) begin
         sh_next  = f_data;
         shc_next = 8'(W);
      end
      if (mrise && st_reg != csc_pkg::ST_INIT) begin
         tot_next = tot_reg + CW'(1);
      end
      unique case (st_reg)
         csc_pkg::ST_ROLE: begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(csc_pkg::ROLE_WAIT - 1)) begin
               // Role is caught once, after reset, from the settled pin
               master_next = cs_now ? ~CASCADE_EN : 1'b1;
               cnt_next    = '0;
               st_next     = csc_pkg::ST_WAIT;
            end
         end
         csc_pkg::ST_WAIT: begin
            if (oe_st && !cs_st) begin
               st_next = csc_pkg::ST_SEND;
            end
         end
         csc_pkg::ST_SEND: begin
            if (master_reg && cs_st && !exh) begin
               st_next = csc_pkg::ST_ERR;
            end else if (exh) begin
               st_next = master_reg ? csc_pkg::ST_CASC : csc_pkg::ST_DONE;
            end
         end
         csc_pkg::ST_CASC: begin
            if (cs_st) begin
               cnt_next = '0;
               st_next  = csc_pkg::ST_INIT;
            end else if (tot_reg == CW'(CHAIN_BITS + csc_pkg::DONE_GRACE)) begin
               cnt_next = '0;
               st_next  = csc_pkg::ST_ERR;
            end
         end
         csc_pkg::ST_INIT: begin
            if (mrise) begin
               cnt_next = cnt_reg + 8'h01;
            end
            if (cnt_reg == 8'(INITC) && tick) begin
               st_next = csc_pkg::ST_IDLE;
            end
         end
         csc_pkg::ST_IDLE: begin
            st_next = csc_pkg::ST_IDLE;
         end
         csc_pkg::ST_ERR: begin
            if (cnt_reg != 8'(EHOLD - 1)) begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         csc_pkg::ST_DONE: begin
            st_next = csc_pkg::ST_DONE;
         end
         default: begin
            st_next = csc_pkg::ST_WAIT;
         end
      endcase
      if (flush) begin
         addr_next = '0;
         tot_next  = '0;
         cnt_next  = '0;
         shc_next  = '0;
         div_next  = '0;
         cclk_next = 1'b0;
         st_next   = csc_pkg::ST_WAIT;
      end
      casc_n_next = ~(CASCADE_EN & (addr_next == AW'(OWN_BITS)));
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg     <= csc_pkg::ST_ROLE;
         master_reg <= 1'b0;
         addr_reg   <= '0;
         tot_reg    <= '0;
         cnt_reg    <= '0;
         div_reg    <= '0;
         cclk_reg   <= 1'b0;
         sh_reg     <= '0;
         shc_reg    <= '0;
         casc_n_reg <= 1'b1;
         rise_d_reg <= 1'b0;
      end else begin
         st_reg     <= st_next;
         master_reg <= master_next;
         addr_reg   <= addr_next;
         tot_reg    <= tot_next;
         cnt_reg    <= cnt_next;
         div_reg    <= div_next;
         cclk_reg   <= cclk_next;
         sh_reg     <= sh_next;
         shc_reg    <= shc_next;
         casc_n_reg <= casc_n_next;
         rise_d_reg <= rise_d_next;
      end
   end

   // ------------------------------------------------------------
   // Init-config pulse
   // ------------------------------------------------------------
   logic [7:0] ini_reg, ini_next;

   always_comb begin
      ini_next = (ini_reg != '0) ? ini_reg - 8'h01 : 8'h00;
      if (i_init_config_instruction) begin
         ini_next = 8'(csc_pkg::INIT_PULSE);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ini_reg <= '0;
      end else begin
         ini_reg <= ini_next;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Output-enable is pulled low only while the role is settling
   assign o_oe_out             = 1'b0;
   assign o_oe_oe_n            = st_reg != csc_pkg::ST_ROLE;
   assign o_config_clock       = cclk_reg;
   assign o_config_clock_oe_n  = ~master_reg;
   assign o_data               = sh_reg[0];
   assign o_data_oe_n          = ~((st_reg == csc_pkg::ST_SEND) & oe_st
                                 & ~cs_st & ~exh);
   assign o_cascade_out_n      = casc_n_reg;
   assign o_target_status_n    = 1'b0;
   assign o_target_status_oe_n = st_reg != csc_pkg::ST_ERR;
   assign o_init_config_out_n  = 1'b0;
   assign o_init_config_oe_n   = ini_reg == '0;
   assign o_mem_rewind         = flush;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   property p_casc;
      (addr_reg == AW'(OWN_BITS)) |-> (o_cascade_out_n == ~CASCADE_EN);
   endproperty
   a_casc: assert property (p_casc) else $error("cascade wrong");

   property p_init_pulse;
      i_init_config_instruction |=> !o_init_config_oe_n [*8];
   endproperty
   a_init_pulse: assert property (p_init_pulse)
      else $error("init-config pulse short");

   property p_slave_clk;
      !master_reg |-> o_config_clock_oe_n && !o_config_clock;
   endproperty
   a_slave_clk: assert property (p_slave_clk)
      else $error("slave drives clock");

   property p_sixteen;
      (st_reg == csc_pkg::ST_INIT && st_next == csc_pkg::ST_IDLE)
         |-> cnt_reg == 8'(INITC);
   endproperty
   a_sixteen: assert property (p_sixteen)
      else $error("trailing clock count wrong");

   property p_idle;
      st_reg == csc_pkg::ST_IDLE |=> !o_config_clock && $stable(cclk_reg);
   endproperty
   a_idle: assert property (p_idle) else $error("clock in idle");

   property p_early;
      (st_reg == csc_pkg::ST_SEND && master_reg && cs_st && !exh && oe_st)
         |=> !o_target_status_oe_n;
   endproperty
   a_early: assert property (p_early) else $error("no early error");

   property p_restart;
      (st_reg == csc_pkg::ST_ERR && i_auto_restart && oe_st)
         ##1 (oe_st && i_auto_restart) [*8]
         |-> ##[0:EHOLD] (st_reg == csc_pkg::ST_WAIT);
   endproperty
   a_restart: assert property (p_restart)
      else $error("no auto restart");

   property p_data_sel;
      !o_data_oe_n |-> !cs_st && oe_st && addr_reg < AW'(OWN_BITS);
   endproperty
   a_data_sel: assert property (p_data_sel)
      else $error("data driven unselected");

   property p_count;
      (addr_reg != $past(addr_reg) && addr_reg != '0)
         |-> $past(adv) && addr_reg == $past(addr_reg) + AW'(1);
   endproperty
   a_count: assert property (p_count) else $error("bad count step");

   property p_oe_reset;
      (!oe_st && st_reg != csc_pkg::ST_ROLE)
         |=> addr_reg == '0 && !o_config_clock;
   endproperty
   a_oe_reset: assert property (p_oe_reset)
      else $error("reset by enable failed");
endmodule

// [csc_target_model.sv]
// Partner model: target logic device that samples the serial bitstream
`timescale 1ns/100ps
module csc_target_model (
   input  wire logic        i_clk_wire,
   input  wire logic        i_data_wire,
   input  wire logic        i_clear_n,
   input  wire logic [15:0] i_done_at,
   output logic             o_done,
   output logic [15:0]      o_rises,
   output logic [255:0]     o_bits
);
   // -------------------------------------------------------------
   // Capture on config clock rise
   // -------------------------------------------------------------
   // Done sticks once the expected length has arrived, so a master that
   // keeps clocking cannot drop its own select back low by accident
   always @(posedge i_clk_wire or negedge i_clear_n) begin
      if (!i_clear_n) begin
         o_rises <= 16'h0000;
         o_done  <= 1'b0;
         o_bits  <= {256{1'b0}};
      end else begin
         o_bits[o_rises[7:0]] <= i_data_wire;
         o_rises <= o_rises + 16'h0001;
         o_done  <= o_done | (o_rises + 16'h0001 >= i_done_at);
      end
   end
endmodule

// [tb.sv]
// Testbench: master, error, reset and slave runs of the sequencer
`timescale 1ns/100ps
module tb;
   logic         i_clk_sys      = 1'b0;
   logic         i_resetn       = 1'b0;
   logic         cs_hold        = 1'b0;
   logic         i_oe_in        = 1'b0;
   logic         i_init_config_instruction = 1'b0;
   logic         i_auto_restart = 1'b0;
   logic         i_mem_valid    = 1'b0;
   logic [7:0]   i_mem_data     = 8'h00;
   logic         arm            = 1'b1;
   logic         ext_clk        = 1'b0;
   logic         src_on         = 1'b0;
   logic         hs             = 1'b0;
   logic         last_data      = 1'b0;
   logic [15:0]  done_at        = 16'hffff;
   logic [7:0]   mem_words [16];
   logic [255:0] cap;
   logic [15:0]  rises;
   logic         done, clk_wire, data_wire, i_chip_select_n;
   logic         o_oe_out, o_oe_oe_n, o_config_clock, o_config_clock_oe_n;
   logic         o_data, o_data_oe_n, o_cascade_out_n, o_target_status_n;
   logic         o_target_status_oe_n, o_init_config_out_n;
   logic         o_init_config_oe_n, o_mem_ready, o_mem_rewind;
   int           wi = 0;
   int           err_total = 0;
   int           n_compared = 0;
   int           seed = 32'hcf19da8e;
   int           k, r, a;

   // -------------------------------------------------------------
   // Wires between the parties
   // -------------------------------------------------------------
   assign i_chip_select_n = cs_hold | done;
   // A released data line toggles so a stale bit can never match
   assign data_wire = o_data_oe_n ? ~last_data : o_data;
   // A slave sees the clock that the bench drives in place of a master
   assign clk_wire  = o_config_clock_oe_n ? ext_clk : o_config_clock;

   always #12.5 i_clk_sys = ~i_clk_sys;

   csc_sequencer #(.OWN_BITS(48), .CHAIN_BITS(64)) DUT (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_chip_select_n(i_chip_select_n), .i_oe_in(i_oe_in),
      .o_oe_out(o_oe_out), .o_oe_oe_n(o_oe_oe_n),
      .i_config_clock(clk_wire), .o_config_clock(o_config_clock),
      .o_config_clock_oe_n(o_config_clock_oe_n),
      .o_data(o_data), .o_data_oe_n(o_data_oe_n),
      .o_cascade_out_n(o_cascade_out_n),
      .o_target_status_n(o_target_status_n),
      .o_target_status_oe_n(o_target_status_oe_n),
      .i_init_config_instruction(i_init_config_instruction),
      .o_init_config_out_n(o_init_config_out_n),
      .o_init_config_oe_n(o_init_config_oe_n),
      .i_auto_restart(i_auto_restart), .i_mem_valid(i_mem_valid),
      .o_mem_ready(o_mem_ready), .i_mem_data(i_mem_data),
      .o_mem_rewind(o_mem_rewind)
   );

   csc_target_model TGT (
      .i_clk_wire(clk_wire), .i_data_wire(data_wire),
      .i_clear_n(i_resetn & arm), .i_done_at(done_at),
      .o_done(done), .o_rises(rises), .o_bits(cap)
   );

   // -------------------------------------------------------------
   // Bitstream source: holds a word until it is taken
   // -------------------------------------------------------------
   always @(negedge i_clk_sys) hs = i_mem_valid & o_mem_ready;
   always @(posedge i_clk_sys) begin
      last_data <= data_wire;
      #1;
      if (o_mem_rewind === 1'b1 || !i_resetn) begin
         wi = 0;
         i_mem_valid = 1'b0;
      end else if (!i_mem_valid || hs) begin
         wi = wi + hs;
         i_mem_valid = src_on && ($random(seed) % 4 != 0);
      end
      i_mem_data = mem_words[wi % 16];
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic wait_lvl(ref logic s, input logic v, input int n);
      int c = 0;
      while (s !== v && c < n) begin
         tick(1);
         c++;
      end
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task do_reset(input logic cs);
      i_resetn = 1'b0;
      cs_hold = cs;
      i_oe_in = 1'b0;
      src_on = 1'b0;
      done_at = 16'hffff;
      tick(2);
      i_resetn = 1'b1;
      tick(10);
   endtask

   task conclude();
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge i_clk_sys);
      err_total++;
      conclude();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      for (k = 0; k < 16; k++) mem_words[k] = $random(seed);
      // Master waits with select high while the FIFO fills up
      do_reset(1'b0);
      cs_hold = 1'b1;
      i_oe_in = 1'b1;
      src_on = 1'b1;
      tick(60);
      check(wi, 17);
      check(o_mem_ready, 1'b0);
      done_at = 16'd56;
      cs_hold = 1'b0;
      wait_lvl(o_cascade_out_n, 1'b0, 3000);
      check(o_config_clock_oe_n, 1'b0);
      check(rises, 48);
      for (k = 0; k < 48; k++) begin
         check(cap[k], mem_words[k / 8][k % 8]);
      end
      tick(3);
      check(o_data_oe_n, 1'b1);
      r = rises;
      tick(20);
      check(rises > r, 1'b1);
      wait_lvl(done, 1'b1, 1000);
      r = rises;
      tick(400);
      check(rises - r >= 16 && rises - r <= 17, 1'b1);
      r = rises;
      tick(200);
      check(rises, r);
      check(clk_wire, 1'b0);
      check(o_target_status_oe_n, 1'b1);
      // Select rises early, without and with auto restart
      for (a = 0; a < 2; a++) begin
         do_reset(1'b0);
         i_auto_restart = a[0];
         done_at = 16'd10;
         i_oe_in = 1'b1;
         src_on = 1'b1;
         wait_lvl(o_target_status_oe_n, 1'b0, 2000);
         check(o_target_status_oe_n, 1'b0);
         check(rises < 48, 1'b1);
         done_at = 16'hffff;
         arm = 1'b0;
         tick(1);
         arm = 1'b1;
         wait_lvl(o_mem_rewind, 1'b1, 100);
         check(o_mem_rewind, a[0]);
         tick(2);
         check(o_target_status_oe_n, a[0]);
      end
      // Done never comes after the whole stream
      i_auto_restart = 1'b0;
      do_reset(1'b0);
      i_oe_in = 1'b1;
      src_on = 1'b1;
      wait_lvl(o_target_status_oe_n, 1'b0, 3000);
      check(o_target_status_oe_n, 1'b0);
      check(rises > 48, 1'b1);
      // Output enable low clears the error, then aborts a new send
      i_oe_in = 1'b0;
      tick(6);
      check(o_target_status_oe_n, 1'b1);
      check(o_mem_rewind, 1'b1);
      check(o_cascade_out_n, 1'b1);
      arm = 1'b0;
      tick(1);
      arm = 1'b1;
      i_oe_in = 1'b1;
      tick(150);
      check(cap[7:0], mem_words[0]);
      i_oe_in = 1'b0;
      tick(6);
      r = rises;
      tick(20);
      check(rises, r);
      check(clk_wire, 1'b0);
      // Init-config pulse stretches to a fixed low time
      i_init_config_instruction = 1'b1;
      tick(1);
      i_init_config_instruction = 1'b0;
      tick(1);
      check(o_init_config_oe_n, 1'b0);
      tick(38);
      check(o_init_config_oe_n, 1'b0);
      tick(1);
      check(o_init_config_oe_n, 1'b1);
      // Select high at reset: slave, never drives clock, and drives no data while unselected
      do_reset(1'b1);
      i_oe_in = 1'b1;
      tick(50);
      check(o_config_clock_oe_n, 1'b1);
      check(o_data_oe_n, 1'b1);
      // Selected slave shifts its own bits on the clock it is given
      src_on = 1'b1;
      tick(40);
      cs_hold = 1'b0;
      tick(8);
      for (k = 0; k < 48; k++) begin
         ext_clk = 1'b1;
         tick(8);
         ext_clk = 1'b0;
         tick(8);
      end
      check(rises, 48);
      check(o_cascade_out_n, 1'b0);
      check(o_data_oe_n, 1'b1);
      for (k = 0; k < 48; k++) begin
         check(cap[k], mem_words[k / 8][k % 8]);
      end
      conclude();
   end
endmodule
